// ### common/bci_pkg.sv
// Operation
// - Branch loads 11-bit target into PC 10:0, page latch 4:3 into PC 12:11.
// - Branch takes two instruction cycles.
// - OR literal into W, only zero flag changes.
// - XOR literal into W, only zero flag changes.
// - Destination bit 0 writes W, 1 writes the addressed file register.
// - Increment file register, steer by destination, only zero flag changes.
// - OR W with file register, steer by destination, only zero flag.
// - XOR W with file register, steer by destination, only zero flag.
// - File move copies to W or back to itself, zero flag always updated.
// - Load literal into W, no flag changes.
// - Store W into addressed file register, no flag changes.
// - Interrupt return pops stack into PC and sets global interrupt enable.
// - Literal return loads W with literal, pops stack into PC, two cycles.
// - Subroutine return pops stack into PC, two cycles, no flag changes.
// - Rotate left through carry, steer by destination, only carry changes.
// - Rotate right through carry, steer by destination, only carry changes.
// - Power-down clears watchdog and prescaler, sets timeout, clears powerdown, stops clock.
// - Literal minus W into W, updating carry, digit carry, zero.
// - File minus W, steered by destination, updating carry, digit carry, zero.
// - Swap file nibbles, steer by destination, no flag changes.
// - PC-changing instructions take two cycles, second one a no-operation.
package bci_pkg;

    // Widths
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BRANCH_W = 11;
    localparam int PAGE_W = 5;
    localparam int PAGE_LO = 3;
    localparam int PAGE_HI = 4;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int RADDR_W = 3;
    localparam int DEST_BIT = 7;
    localparam int NIB_W = 4;

    // Clocks per instruction cycle, used for the no-operation slot
    localparam logic [1:0] INSTR_CYCLE_CLKS = 2'h2;

    // Opcode fields
    localparam logic [2:0] OPC_BRANCH = 3'h5;
    localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
    localparam logic [3:0] OPC_RET_LIT = 4'hD;
    localparam logic [4:0] OPC_SUB_LIT = 5'h1E;
    localparam logic [5:0] OPC_OR_LIT = 6'h38;
    localparam logic [5:0] OPC_XOR_LIT = 6'h3A;
    localparam logic [5:0] OPC_SUB_FILE = 6'h02;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [5:0] OPC_XOR_FILE = 6'h06;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
    localparam logic [5:0] OPC_INC_FILE = 6'h0A;
    localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
    localparam logic [5:0] OPC_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OPC_SWAP = 6'h0E;
    localparam logic [6:0] OPC_STORE_W = 7'h01;
    localparam logic [13:0] OPC_RET_SUB = 14'h0008;
    localparam logic [13:0] OPC_RET_INT = 14'h0009;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;

    // Register port offsets
    localparam logic [2:0] REG_PAGE = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_WORK = 3'h2;
    localparam logic [2:0] REG_PC_LO = 3'h3;
    localparam logic [2:0] REG_PC_HI = 3'h4;

    // Status byte layout
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_GIE = 7;

    // Reset values
    localparam logic TO_RST = 1'b1;
    localparam logic PD_RST = 1'b1;
    localparam logic GIE_RST = 1'b0;

    typedef enum logic [4:0] {
        OP_NOP, OP_BRANCH, OP_OR_LIT, OP_XOR_LIT, OP_LOAD_LIT, OP_RET_LIT, OP_SUB_LIT,
        OP_INC_FILE, OP_OR_FILE, OP_XOR_FILE, OP_MOVE_FILE, OP_STORE_W, OP_RET_INT,
        OP_RET_SUB, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_FILE, OP_SWAP, OP_SLEEP
    } bci_op_t;

    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_FLUSH, ST_HALT} bci_state_t;

    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic zero;
    } bci_flags_t;

    typedef struct packed {
        logic wrEn;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bci_file_wr_t;

    typedef struct packed {
        logic counterClear;
        logic prescalerClear;
    } bci_wdt_t;

endpackage

// ### logic/bci_core.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module bci_core import bci_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program memory
    input wire logic instrValid,
    input wire logic [INSTR_W-1:0] instr,
    output logic instrReady,
    output logic [PC_W-1:0] progAddr,
    // Data register file
    output logic [FADDR_W-1:0] fileAddr,
    input wire logic [DATA_W-1:0] fileRdData,
    output bci_file_wr_t fileWr,
    // Return stack push from call and interrupt logic
    input wire logic stackPush,
    input wire logic [PC_W-1:0] stackPushAddr,
    // Watchdog and power
    input wire logic wakeRaw,
    output bci_wdt_t wdtCtl,
    output logic oscStop,
    // Core state
    output bci_flags_t flags,
    output logic [DATA_W-1:0] workReg,
    output logic globalIntEnable,
    output logic timeoutStatus,
    output logic powerdownStatus,
    output logic instrDone,
    // Register port
    input wire logic [RADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData
);

    // Decode one instruction word into an operation
    function automatic bci_op_t decodeOp(input logic [INSTR_W-1:0] w);
        bci_op_t op;
        op = OP_NOP;
        if (w[13:11] == OPC_BRANCH) begin
            op = OP_BRANCH;
        end else if (w[13:10] == OPC_LOAD_LIT) begin
            op = OP_LOAD_LIT;
        end else if (w[13:10] == OPC_RET_LIT) begin
            op = OP_RET_LIT;
        end else if (w[13:9] == OPC_SUB_LIT) begin
            op = OP_SUB_LIT;
        end else if (w == OPC_RET_SUB) begin
            op = OP_RET_SUB;
        end else if (w == OPC_RET_INT) begin
            op = OP_RET_INT;
        end else if (w == OPC_SLEEP) begin
            op = OP_SLEEP;
        end else if (w[13:7] == OPC_STORE_W) begin
            op = OP_STORE_W;
        end else begin
            case (w[13:8])
                OPC_OR_LIT: op = OP_OR_LIT;
                OPC_XOR_LIT: op = OP_XOR_LIT;
                OPC_SUB_FILE: op = OP_SUB_FILE;
                OPC_OR_FILE: op = OP_OR_FILE;
                OPC_XOR_FILE: op = OP_XOR_FILE;
                OPC_MOVE_FILE: op = OP_MOVE_FILE;
                OPC_INC_FILE: op = OP_INC_FILE;
                OPC_ROT_RIGHT: op = OP_ROT_RIGHT;
                OPC_ROT_LEFT: op = OP_ROT_LEFT;
                OPC_SWAP: op = OP_SWAP;
                default: op = OP_NOP;
            endcase
        end
        return op;
    endfunction

    // Zero test on an 8-bit result
    function automatic logic isZero(input logic [DATA_W-1:0] v);
        return (v == '0);
    endfunction

    // Two's complement a - b; returns {carry, digitCarry, difference}
    function automatic logic [DATA_W+1:0] subTwos(input logic [DATA_W-1:0] a,
                                                  input logic [DATA_W-1:0] b);
        logic [DATA_W:0] full;
        logic [NIB_W:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
        low = {1'b0, a[NIB_W-1:0]} + {1'b0, ~b[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
        return {full[DATA_W], low[NIB_W], full[DATA_W-1:0]};
    endfunction

    bci_state_t state_q, state_d;
    bci_op_t op_q;
    logic [INSTR_W-1:0] ir_q;
    logic [PC_W-1:0] pc_q;
    logic [DATA_W-1:0] work_q;
    bci_flags_t flags_q;
    logic gie_q, timeout_q, powerdown_q, oscStop_q;
    logic [PAGE_W-1:0] page_q;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [1:0] flushCnt_q;
    logic wakeMeta_q, wakeSync_q;
    logic instrReady_q, instrDone_q;
    logic [FADDR_W-1:0] fileAddr_q;
    bci_file_wr_t fileWr_q;
    bci_wdt_t wdt_q;
    logic [DATA_W-1:0] regRdData_q;

    // Execute-stage results
    logic [DATA_W-1:0] res;
    logic steer, wrW, wrF, popStack, twoCycle, setGie, sleepReq, execNow;
    bci_flags_t flagsNew;
    logic [PC_W-1:0] pcNext, stackTop;
    logic [DATA_W+1:0] subOut;
    logic [DATA_W-1:0] lit;

    assign execNow = (state_q == ST_EXEC);
    assign stackTop = stack_q[sp_q - 1'b1];
    assign lit = ir_q[DATA_W-1:0];

    // Operation semantics for the instruction held in the execute stage
    always_comb begin
        res = '0;
        steer = 1'b0;
        wrW = 1'b0;
        wrF = 1'b0;
        popStack = 1'b0;
        twoCycle = 1'b0;
        setGie = 1'b0;
        sleepReq = 1'b0;
        flagsNew = flags_q;
        pcNext = pc_q + 1'b1;
        subOut = '0;
        case (op_q)
            OP_BRANCH: begin
                pcNext = {page_q[PAGE_HI:PAGE_LO], ir_q[BRANCH_W-1:0]};
                twoCycle = 1'b1;
            end
            OP_OR_LIT: begin
                res = work_q | lit;
                wrW = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_XOR_LIT: begin
                res = work_q ^ lit;
                wrW = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_LOAD_LIT: begin
                res = lit;
                wrW = 1'b1;
            end
            OP_RET_LIT: begin
                res = lit;
                wrW = 1'b1;
                pcNext = stackTop;
                popStack = 1'b1;
                twoCycle = 1'b1;
            end
            OP_SUB_LIT: begin
                subOut = subTwos(lit, work_q);
                res = subOut[DATA_W-1:0];
                wrW = 1'b1;
                flagsNew.carry = subOut[DATA_W+1];
                flagsNew.digitCarry = subOut[DATA_W];
                flagsNew.zero = isZero(res);
            end
            OP_INC_FILE: begin
                res = fileRdData + 1'b1;
                steer = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_OR_FILE: begin
                res = work_q | fileRdData;
                steer = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_XOR_FILE: begin
                res = work_q ^ fileRdData;
                steer = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_MOVE_FILE: begin
                res = fileRdData;
                steer = 1'b1;
                flagsNew.zero = isZero(res);
            end
            OP_STORE_W: begin
                res = work_q;
                wrF = 1'b1;
            end
            OP_RET_INT: begin
                pcNext = stackTop;
                popStack = 1'b1;
                setGie = 1'b1;
                twoCycle = 1'b1;
            end
            OP_RET_SUB: begin
                pcNext = stackTop;
                popStack = 1'b1;
                twoCycle = 1'b1;
            end
            OP_ROT_LEFT: begin
                res = {fileRdData[DATA_W-2:0], flags_q.carry};
                flagsNew.carry = fileRdData[DATA_W-1];
                steer = 1'b1;
            end
            OP_ROT_RIGHT: begin
                res = {flags_q.carry, fileRdData[DATA_W-1:1]};
                flagsNew.carry = fileRdData[0];
                steer = 1'b1;
            end
            OP_SUB_FILE: begin
                subOut = subTwos(fileRdData, work_q);
                res = subOut[DATA_W-1:0];
                steer = 1'b1;
                flagsNew.carry = subOut[DATA_W+1];
                flagsNew.digitCarry = subOut[DATA_W];
                flagsNew.zero = isZero(res);
            end
            OP_SWAP: begin
                res = {fileRdData[NIB_W-1:0], fileRdData[DATA_W-1:NIB_W]};
                steer = 1'b1;
            end
            OP_SLEEP: begin
                sleepReq = 1'b1;
            end
            default: begin
                res = '0;
            end
        endcase
        // Destination select for file-register operations
        if (steer) begin
            wrW = ~ir_q[DEST_BIT];
            wrF = ir_q[DEST_BIT];
        end
    end

    // Control sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_FETCH: begin
                if (instrValid) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (sleepReq) begin
                    state_d = ST_HALT;
                end else if (twoCycle) begin
                    state_d = ST_FLUSH;
                end else begin
                    state_d = ST_FETCH;
                end
            end
            ST_FLUSH: begin
                if (flushCnt_q == 2'h1) begin
                    state_d = ST_FETCH;
                end
            end
            ST_HALT: begin
                if (wakeSync_q) begin
                    state_d = ST_FETCH;
                end
            end
            default: state_d = ST_FETCH;
        endcase
    end

    // State register and handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_FETCH;
            instrReady_q <= 1'b0;
            instrDone_q <= 1'b0;
        end else begin
            state_q <= state_d;
            instrReady_q <= (state_d == ST_FETCH);
            instrDone_q <= execNow;
        end
    end

    // No-operation slot spans one full instruction cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flushCnt_q <= '0;
        end else if (execNow && twoCycle) begin
            flushCnt_q <= INSTR_CYCLE_CLKS;
        end else if (state_q == ST_FLUSH) begin
            flushCnt_q <= flushCnt_q - 1'b1;
        end
    end

    // Instruction latch and file address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_q <= '0;
            op_q <= OP_NOP;
            fileAddr_q <= '0;
        end else if (state_q == ST_FETCH && instrValid) begin
            ir_q <= instr;
            op_q <= decodeOp(instr);
            fileAddr_q <= instr[FADDR_W-1:0];
        end
    end

    // Program counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= '0;
        end else if (execNow) begin
            pc_q <= pcNext;
        end
    end

    // Return stack, circular over its eight levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= '0;
            end
        end else if (execNow && popStack && stackPush) begin
            stack_q[sp_q - 1'b1] <= stackPushAddr;
        end else if (execNow && popStack) begin
            sp_q <= sp_q - 1'b1;
        end else if (stackPush) begin
            stack_q[sp_q] <= stackPushAddr;
            sp_q <= sp_q + 1'b1;
        end
    end

    // Working register; execution wins over a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_q <= '0;
        end else if (execNow && wrW) begin
            work_q <= res;
        end else if (regWr && regAddr == REG_WORK) begin
            work_q <= regWrData;
        end
    end

    // Arithmetic flags and interrupt enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
            gie_q <= GIE_RST;
        end else begin
            if (execNow) begin
                flags_q <= flagsNew;
            end else if (regWr && regAddr == REG_STATUS) begin
                flags_q.carry <= regWrData[ST_CARRY];
                flags_q.digitCarry <= regWrData[ST_DIGIT];
                flags_q.zero <= regWrData[ST_ZERO];
            end
            if (execNow && setGie) begin
                gie_q <= 1'b1;
            end else if (regWr && regAddr == REG_STATUS) begin
                gie_q <= regWrData[ST_GIE];
            end
        end
    end

    // File register write-back, one-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fileWr_q <= '0;
        end else begin
            fileWr_q.wrEn <= execNow && wrF;
            fileWr_q.addr <= fileAddr_q;
            fileWr_q.data <= res;
        end
    end

    // Wake input synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeMeta_q <= 1'b0;
            wakeSync_q <= 1'b0;
        end else begin
            wakeMeta_q <= wakeRaw;
            wakeSync_q <= wakeMeta_q;
        end
    end

    // Power-down entry: watchdog clear, status bits, oscillator stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_q <= '0;
            timeout_q <= TO_RST;
            powerdown_q <= PD_RST;
            oscStop_q <= 1'b0;
        end else begin
            wdt_q.counterClear <= execNow && sleepReq;
            wdt_q.prescalerClear <= execNow && sleepReq;
            if (execNow && sleepReq) begin
                timeout_q <= 1'b1;
                powerdown_q <= 1'b0;
                oscStop_q <= 1'b1;
            end else if (state_q == ST_HALT && wakeSync_q) begin
                oscStop_q <= 1'b0;
            end
        end
    end

    // Page latch, written by software only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= '0;
        end else if (regWr && regAddr == REG_PAGE) begin
            page_q <= regWrData[PAGE_W-1:0];
        end
    end

    // Register read port, data valid for one cycle only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_q <= '0;
        end else if (regRd) begin
            case (regAddr)
                REG_PAGE: regRdData_q <= {{(DATA_W-PAGE_W){1'b0}}, page_q};
                REG_STATUS: begin
                    regRdData_q <= '0;
                    regRdData_q[ST_CARRY] <= flags_q.carry;
                    regRdData_q[ST_DIGIT] <= flags_q.digitCarry;
                    regRdData_q[ST_ZERO] <= flags_q.zero;
                    regRdData_q[ST_PD] <= powerdown_q;
                    regRdData_q[ST_TO] <= timeout_q;
                    regRdData_q[ST_GIE] <= gie_q;
                end
                REG_WORK: regRdData_q <= work_q;
                REG_PC_LO: regRdData_q <= pc_q[DATA_W-1:0];
                REG_PC_HI: regRdData_q <= {{(2*DATA_W-PC_W){1'b0}}, pc_q[PC_W-1:DATA_W]};
                default: regRdData_q <= '0;
            endcase
        end else begin
            regRdData_q <= '0;
        end
    end

    // Outputs
    assign instrReady = instrReady_q;
    assign progAddr = pc_q;
    assign fileAddr = fileAddr_q;
    assign fileWr = fileWr_q;
    assign wdtCtl = wdt_q;
    assign oscStop = oscStop_q;
    assign flags = flags_q;
    assign workReg = work_q;
    assign globalIntEnable = gie_q;
    assign timeoutStatus = timeout_q;
    assign powerdownStatus = powerdown_q;
    assign instrDone = instrDone_q;
    assign regRdData = regRdData_q;

endmodule

// ### tb/bci_core_sva.sv
`timescale 1ns/1ps
module bci_core_sva import bci_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction port
    input wire logic instrValid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instrReady,
    input wire logic [PC_W-1:0] progAddr,
    // Data side and core state
    input wire logic [DATA_W-1:0] fileRdData,
    input wire bci_file_wr_t fileWr,
    input wire bci_wdt_t wdtCtl,
    input wire bci_flags_t flags,
    input wire logic [DATA_W-1:0] workReg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Instruction taken on this edge
    logic tk;
    assign tk = instrValid && instrReady;
    a_branch_target: assert property (tk && instr[13:11] == OPC_BRANCH |-> ##2
        progAddr[10:0] == $past(instr[10:0], 2)) else $error("branch target wrong");
    a_pc_change_slot: assert property (tk && (
        instr[13:11] == OPC_BRANCH
        || instr[13:10] == OPC_RET_LIT || instr == OPC_RET_SUB || instr == OPC_RET_INT)
        |=> !instrReady [*3] ##1 instrReady) else $error("no-op slot wrong");
    a_store_work: assert property (tk && instr[13:7] == OPC_STORE_W |-> ##2 fileWr.wrEn
        && fileWr.addr == $past(instr[6:0], 2) && fileWr.data == $past(workReg, 2))
        else $error("store wrong");
    a_dest_work: assert property (tk && instr[13:12] == 2'h0 && instr[11:8] != 4'h0
        && !instr[DEST_BIT] |-> ##2 !fileWr.wrEn) else $error("file written with d clear");
    a_swap_nibbles: assert property (tk && instr[13:8] == OPC_SWAP && instr[DEST_BIT]
        |-> ##2 fileWr.wrEn && fileWr.data == {$past(fileRdData[3:0]), $past(fileRdData[7:4])}
        && flags == $past(flags, 2)) else $error("swap wrong");
    a_rotate_left: assert property (tk && instr[13:8] == OPC_ROT_LEFT
        && !instr[DEST_BIT] |-> ##2 workReg == {$past(fileRdData[6:0]), $past(flags.carry, 2)}
        && flags.carry == $past(fileRdData[7])) else $error("rotate left wrong");
    a_sub_literal: assert property (tk && instr[13:9] == OPC_SUB_LIT |-> ##2
        workReg == $past(instr[7:0], 2) - $past(workReg, 2)
        && flags.carry == ($past(instr[7:0], 2) >= $past(workReg, 2))) else $error("sub wrong");
    a_sleep_watchdog: assert property (tk && instr == OPC_SLEEP |-> ##[1:3]
        (wdtCtl.counterClear && wdtCtl.prescalerClear)) else $error("watchdog not cleared");
endmodule

bind bci_core bci_core_sva bci_core_sva_inst (
    .clk, .rst_n, .instrValid, .instr, .instrReady, .progAddr,
    .fileRdData, .fileWr, .wdtCtl, .flags, .workReg
);

// ### tb/bci_file_model.sv
`timescale 1ns/1ps
module bci_file_model import bci_pkg::*; (
    // Clock
    input wire logic clk,
    // Register file port
    input wire logic [FADDR_W-1:0] fileAddr,
    output logic [DATA_W-1:0] fileRdData,
    input wire bci_file_wr_t fileWr
);
    logic [DATA_W-1:0] mem [128] = '{default: 8'h00};
    // Read follows the address at once
    assign fileRdData = mem[fileAddr];
    // Write on the core's pulse
    always @(posedge clk) begin
        if (fileWr.wrEn) begin
            mem[fileWr.addr] <= fileWr.data;
        end
    end
endmodule

// ### tb/bci_core_bench.sv
`timescale 1ns/1ps
module bci_core_bench import bci_pkg::*; ;
    // Stimulus, observed outputs and bookkeeping
    logic clk = 1'b0, rst_n = 1'b0, instrValid = 1'b0, stackPush = 1'b0, wakeRaw = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, ec, ez;
    logic instrReady, oscStop, globalIntEnable, timeoutStatus, powerdownStatus, instrDone;
    logic [INSTR_W-1:0] instr = '0;
    logic [PC_W-1:0] stackPushAddr = '0, progAddr;
    logic [FADDR_W-1:0] fileAddr;
    logic [RADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0, fileRdData, workReg, regRdData, rv, wv, fv;
    logic [8:0] r;
    bci_file_wr_t fileWr;
    bci_wdt_t wdtCtl;
    bci_flags_t flags;
    int bad_count = 0, n_compared = 0, cyc = 0, tn = 0;
    logic [5:0] ops [8] = '{OPC_ROT_LEFT, OPC_ROT_RIGHT, OPC_SWAP, OPC_SUB_FILE,
        OPC_OR_FILE, OPC_XOR_FILE, OPC_MOVE_FILE, OPC_INC_FILE};

    bci_core bci_core_inst (.clk, .rst_n, .instrValid, .instr, .instrReady, .progAddr,
        .fileAddr, .fileRdData, .fileWr, .stackPush, .stackPushAddr, .wakeRaw, .wdtCtl,
        .oscStop, .flags, .workReg, .globalIntEnable, .timeoutStatus, .powerdownStatus,
        .instrDone, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
    bci_file_model bci_file_model_inst (.clk, .fileAddr, .fileRdData, .fileWr);

    // Clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic fin();
        tn++;
        $display("test %0d done", tn);
    endtask
    // Bounded wait; sleep leaves it by count
    task automatic waitRdy();
        for (int i = 0; i < 20 && instrReady !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic exec(input logic [INSTR_W-1:0] w);
        waitRdy();
        @(posedge clk);
        instrValid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        waitRdy();
    endtask
    task automatic wr(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [RADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic push(input logic [PC_W-1:0] a);
        @(posedge clk);
        stackPush <= 1'b1;
        stackPushAddr <= a;
        @(posedge clk);
        stackPush <= 1'b0;
    endtask
    // Expected {carry, result} of a file operation
    function automatic logic [8:0] fres(input logic [5:0] op, input logic [7:0] f, w,
        input logic c);
        case (op)
            OPC_SUB_FILE: return {f >= w, f - w};
            OPC_OR_FILE: return {c, f | w};
            OPC_XOR_FILE: return {c, f ^ w};
            OPC_INC_FILE: return {c, f + 8'h01};
            OPC_ROT_RIGHT: return {f[0], c, f[7:1]};
            OPC_ROT_LEFT: return {f[7], f[6:0], c};
            OPC_SWAP: return {c, f[3:0], f[7:4]};
            default: return {c, f};
        endcase
    endfunction

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({timeoutStatus, powerdownStatus, globalIntEnable}, 3'b110);
        wr(REG_WORK, 8'h5a);
        rd(REG_WORK, rv);
        chk(rv, 8'h5a);
        rd(3'h7, rv);
        chk(rv, 8'h00);
        rd(REG_STATUS, rv);
        chk(rv, 8'h18);
        fin();
        exec({OPC_OR_LIT, 8'h81});
        chk({flags.zero, workReg}, 9'h0db);
        exec({OPC_XOR_LIT, 8'hdb});
        chk({flags.zero, workReg}, 9'h100);
        exec({OPC_LOAD_LIT, 2'b00, 8'h81});
        chk({flags.zero, workReg}, 9'h181);
        for (int j = 0; j < 2; j++) begin
            wv = j ? 8'h3c : 8'h10;
            fv = j ? 8'h3c : 8'h0f;
            exec({OPC_LOAD_LIT, 2'b00, wv});
            exec({OPC_SUB_LIT, 1'b0, fv});
            r = {1'b0, fv - wv};
            chk({flags, workReg}, {fv >= wv, fv[3:0] >= wv[3:0], !r, r[7:0]});
        end
        fin();
        ec = 1'b1;
        ez = 1'b1;
        for (int i = 0; i < 16; i++) begin
            exec({OPC_LOAD_LIT, 2'b00, 8'hf3});
            exec({OPC_STORE_W, 7'h15});
            exec({OPC_LOAD_LIT, 2'b00, 8'h3c});
            exec({ops[i/2], i[0], 7'h15});
            @(posedge clk);
            #1;
            r = fres(ops[i/2], 8'hf3, 8'h3c, ec);
            ez = (i < 6) ? ez : (r[7:0] == 8'h00);
            chk(workReg, i[0] ? 8'h3c : r[7:0]);
            chk(bci_file_model_inst.mem[7'h15], i[0] ? r[7:0] : 8'hf3);
            chk({flags.carry, flags.zero}, {r[8], ez});
            ec = r[8];
        end
        fin();
        wr(REG_PAGE, 8'h18);
        exec({OPC_BRANCH, 11'h2ab});
        chk(progAddr, 13'h1aab);
        push(13'h0abc);
        exec(OPC_RET_SUB);
        chk(progAddr, 13'h0abc);
        push(13'h0123);
        exec({OPC_RET_LIT, 2'b00, 8'h77});
        chk({progAddr, workReg}, {13'h0123, 8'h77});
        push(13'h1555);
        exec(OPC_RET_INT);
        chk({globalIntEnable, progAddr}, {1'b1, 13'h1555});
        chk({flags.carry, flags.zero}, {ec, ez});
        fin();
        exec(OPC_SLEEP);
        chk({oscStop, timeoutStatus, powerdownStatus, instrReady}, 4'b1100);
        @(posedge clk);
        wakeRaw <= 1'b1;
        exec({OPC_LOAD_LIT, 2'b00, 8'h42});
        chk({instrDone, fileAddr, workReg}, {1'b1, 7'h42, 8'h42});
        fin();
        conclude();
    end
endmodule
